//--- logic/can_filter_pkg.sv
package can_filter_pkg;

	// apb address and data
	localparam int unsigned ADDR_WIDTH = 12;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned STRB_WIDTH = 4;
	localparam int unsigned LANE_WIDTH = 8;

	// register offsets (byte addresses)
	localparam logic [11:0] FILTER4_7_OFFSET = 12'h000;
	localparam logic [11:0] FILTER8_11_OFFSET = 12'h004;
	localparam logic [11:0] FILTER12_15_OFFSET = 12'h008;
	localparam logic [11:0] ROUTE_STATUS_OFFSET = 12'h00C;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// pointer bank layout
	localparam int unsigned PTR_WIDTH = 4;
	localparam int unsigned REG_WIDTH = 16;
	localparam int unsigned FIELDS_PER_REG = 4;
	localparam int unsigned REG_COUNT = 3;
	localparam int unsigned FILTER_COUNT = 12;
	localparam int unsigned BANK_WIDTH = 48;
	localparam logic [3:0] FIRST_FILTER = 4'h4;

	// common pointer encoding
	localparam logic [3:0] PTR_RESET = 4'h0;
	localparam logic [3:0] FIFO_CODE = 4'hF;
	localparam int unsigned BUFFER_COUNT = 15;

	// route status register layout
	localparam int unsigned STATUS_CODE_LSB = 0;
	localparam int unsigned STATUS_FILTER_LSB = 4;
	localparam int unsigned STATUS_FIFO_BIT = 8;
	localparam int unsigned STATUS_FOREIGN_BIT = 9;
	localparam int unsigned STATUS_SEEN_BIT = 10;

	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

//--- logic/apb_reg_decode.sv
`timescale 1ns/1ps
module apb_reg_decode (
	input wire logic [11:0] paddr,
	output logic [2:0] reg_sel,
	output logic status_sel,
	output logic addr_hit
);
	logic aligned;

	// misaligned byte addresses are treated as unmapped
	assign aligned = (paddr[1:0] == can_filter_pkg::WORD_ALIGN);
	assign reg_sel[0] = aligned && (paddr == can_filter_pkg::FILTER4_7_OFFSET);
	assign reg_sel[1] = aligned && (paddr == can_filter_pkg::FILTER8_11_OFFSET);
	assign reg_sel[2] = aligned && (paddr == can_filter_pkg::FILTER12_15_OFFSET);
	assign status_sel = aligned && (paddr == can_filter_pkg::ROUTE_STATUS_OFFSET);
	assign addr_hit = (|reg_sel) || status_sel;
endmodule

//--- logic/buffer_pointer_decode.sv
`timescale 1ns/1ps
module buffer_pointer_decode (
	input wire logic [3:0] ptr_code,
	output logic to_fifo,
	output logic [14:0] buffer_select
);
	// all-ones code sends the message to the fifo
	assign to_fifo = (ptr_code == can_filter_pkg::FIFO_CODE); // RULE_05

	// codes 0 to 14 select the buffer of that number
	for (genvar b = 0; b < can_filter_pkg::BUFFER_COUNT; b++) begin : g_sel
		assign buffer_select[b] = (ptr_code == 4'(b)); // RULE_06
	end
endmodule

//--- logic/can_filter_buffer_pointer.sv
// Contract
// RULE_01: filter 4 pointer sits in bits 3-0 of the filter 4-7 register.
// RULE_02: filter 11 pointer sits in bits 15-12 of the filter 8-11 register.
// RULE_03: filter 10 pointer sits in bits 11-8 of the filter 8-11 register.
// RULE_04: filter 9 pointer sits in bits 7-4 of the filter 8-11 register.
// RULE_05: pointer code 1111 routes accepted messages into the receive fifo.
// RULE_06: code 1110 selects buffer 14; lower codes select the buffer of that number.
// RULE_07: code 0001 routes accepted messages to buffer 1.
// RULE_08: code 0000 routes accepted messages to buffer 0.
// RULE_09: filters 14, 13, 12 sit in bits 11-8, 7-4, 3-0 of the 12-15 register.
// RULE_10: every pointer is software read/write and clears to zero at reset.
`timescale 1ns/1ps
module can_filter_buffer_pointer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hit_valid,
	input wire logic [3:0] hit_filter,
	output logic route_valid,
	output logic route_to_fifo,
	output logic [3:0] route_buffer,
	output logic [14:0] route_buffer_select,
	output logic route_foreign,
	output logic [3:0] filter4_dest_ptr,
	output logic [3:0] filter5_dest_ptr,
	output logic [3:0] filter6_dest_ptr,
	output logic [3:0] filter7_dest_ptr,
	output logic [3:0] filter8_dest_ptr,
	output logic [3:0] filter9_dest_ptr,
	output logic [3:0] filter10_dest_ptr,
	output logic [3:0] filter11_dest_ptr,
	output logic [3:0] filter12_dest_ptr,
	output logic [3:0] filter13_dest_ptr,
	output logic [3:0] filter14_dest_ptr,
	output logic [3:0] filter15_dest_ptr
);

	logic [2:0] reg_sel;
	logic status_sel;
	logic addr_hit;
	logic setup_phase;
	logic access_phase;
	logic write_access;
	logic [47:0] ptr_bank;
	logic [31:0] next_prdata;
	logic [15:0] reg_word [3];

	logic lookup_foreign;
	logic [3:0] lookup_index;
	logic [3:0] lookup_code;
	logic lookup_fifo;
	logic [14:0] lookup_select;

	logic [3:0] last_filter;
	logic [3:0] last_code;
	logic last_fifo;
	logic last_foreign;
	logic route_seen;
	logic [31:0] status_word;

	// address decode

	apb_reg_decode u_decode (
		.paddr(paddr),
		.reg_sel(reg_sel),
		.status_sel(status_sel),
		.addr_hit(addr_hit)
	);

	// apb handshake: zero wait states, error on unmapped access

	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign write_access = access_phase && pwrite && addr_hit;
	assign pready = 1'b1;
	assign pslverr = access_phase && !addr_hit;

	// pointer bank: one field per filter, packed so that each register
	// reads back as a straight 16-bit slice of the bank

	for (genvar g = 0; g < can_filter_pkg::FILTER_COUNT; g++) begin : g_field
		localparam int unsigned REG_IDX = g / can_filter_pkg::FIELDS_PER_REG;
		localparam int unsigned FIELD_IDX = g % can_filter_pkg::FIELDS_PER_REG;
		localparam int unsigned BIT_LSB = FIELD_IDX * can_filter_pkg::PTR_WIDTH;
		localparam int unsigned LANE_IDX = BIT_LSB / can_filter_pkg::LANE_WIDTH;
		logic [3:0] ptr;

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				ptr <= can_filter_pkg::PTR_RESET; // RULE_10
			end else if (write_access && reg_sel[REG_IDX] && pstrb[LANE_IDX]) begin
				ptr <= pwdata[BIT_LSB +: can_filter_pkg::PTR_WIDTH]; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_09
			end
		end

		assign ptr_bank[g * can_filter_pkg::PTR_WIDTH +: can_filter_pkg::PTR_WIDTH] = ptr;
	end

	assign filter4_dest_ptr = ptr_bank[3:0]; // RULE_01
	assign filter5_dest_ptr = ptr_bank[7:4];
	assign filter6_dest_ptr = ptr_bank[11:8];
	assign filter7_dest_ptr = ptr_bank[15:12];
	assign filter8_dest_ptr = ptr_bank[19:16];
	assign filter9_dest_ptr = ptr_bank[23:20]; // RULE_04
	assign filter10_dest_ptr = ptr_bank[27:24]; // RULE_03
	assign filter11_dest_ptr = ptr_bank[31:28]; // RULE_02
	assign filter12_dest_ptr = ptr_bank[35:32]; // RULE_09
	assign filter13_dest_ptr = ptr_bank[39:36]; // RULE_09
	assign filter14_dest_ptr = ptr_bank[43:40]; // RULE_09
	assign filter15_dest_ptr = ptr_bank[47:44];

	// route status word, read-only

	always_comb begin
		status_word = can_filter_pkg::READ_ZERO;
		status_word[can_filter_pkg::STATUS_CODE_LSB +: can_filter_pkg::PTR_WIDTH] = last_code;
		status_word[can_filter_pkg::STATUS_FILTER_LSB +: can_filter_pkg::PTR_WIDTH] = last_filter;
		status_word[can_filter_pkg::STATUS_FIFO_BIT] = last_fifo;
		status_word[can_filter_pkg::STATUS_FOREIGN_BIT] = last_foreign;
		status_word[can_filter_pkg::STATUS_SEEN_BIT] = route_seen;
	end

	// read mux; upper half of every pointer word reads as zero

	for (genvar r = 0; r < can_filter_pkg::REG_COUNT; r++) begin : g_word
		assign reg_word[r] = ptr_bank[r * can_filter_pkg::REG_WIDTH +: can_filter_pkg::REG_WIDTH];
	end

	// the address decode is one-hot, so no priority is needed between words
	always_comb begin
		next_prdata = can_filter_pkg::READ_ZERO;
		for (int r = 0; r < can_filter_pkg::REG_COUNT; r++) begin
			if (reg_sel[r]) begin
				next_prdata[can_filter_pkg::REG_WIDTH - 1:0] = reg_word[r]; // RULE_10
			end
		end
		if (status_sel) begin
			next_prdata = status_word;
		end
	end

	// read data is captured in the setup cycle so that it is a flop output
	// throughout the access phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= can_filter_pkg::READ_ZERO;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// routing lookup for an accepted message

	// filters 0 to 3 belong to another bank and are flagged, not routed
	assign lookup_foreign = (hit_filter < can_filter_pkg::FIRST_FILTER);
	assign lookup_index = hit_filter - can_filter_pkg::FIRST_FILTER;

	// a plain mux keeps foreign indexes from selecting past the end of the bank
	always_comb begin
		lookup_code = can_filter_pkg::PTR_RESET;
		for (int k = 0; k < can_filter_pkg::FILTER_COUNT; k++) begin
			if (!lookup_foreign && lookup_index == 4'(k)) begin
				lookup_code = ptr_bank[k * can_filter_pkg::PTR_WIDTH +: can_filter_pkg::PTR_WIDTH];
			end
		end
	end

	buffer_pointer_decode u_ptr_decode (
		.ptr_code(lookup_code),
		.to_fifo(lookup_fifo),
		.buffer_select(lookup_select)
	);

	// a write in the same cycle as a hit does not affect that hit:
	// the lookup sees the pointer as it stood before the edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_valid <= 1'b0;
		end else begin
			route_valid <= hit_valid;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_foreign <= 1'b0;
		end else if (hit_valid) begin
			route_foreign <= lookup_foreign;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_to_fifo <= 1'b0;
		end else if (hit_valid) begin
			route_to_fifo <= lookup_fifo && !lookup_foreign; // RULE_05
		end
	end

	// fifo and foreign hits select no dedicated buffer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_buffer <= can_filter_pkg::PTR_RESET;
		end else if (hit_valid && (lookup_fifo || lookup_foreign)) begin
			route_buffer <= can_filter_pkg::PTR_RESET;
		end else if (hit_valid) begin
			route_buffer <= lookup_code; // RULE_06 RULE_07 RULE_08
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_buffer_select <= '0;
		end else if (hit_valid && (lookup_fifo || lookup_foreign)) begin
			route_buffer_select <= '0;
		end else if (hit_valid) begin
			route_buffer_select <= lookup_select; // RULE_06 RULE_07 RULE_08
		end
	end

	// last route, visible to software

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_filter <= can_filter_pkg::PTR_RESET;
		end else if (hit_valid) begin
			last_filter <= hit_filter;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_code <= can_filter_pkg::PTR_RESET;
		end else if (hit_valid) begin
			last_code <= lookup_code;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_fifo <= 1'b0;
		end else if (hit_valid) begin
			last_fifo <= lookup_fifo && !lookup_foreign;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_foreign <= 1'b0;
		end else if (hit_valid) begin
			last_foreign <= lookup_foreign;
		end
	end

	// sticky until reset; no software clear exists, so nothing can race it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_seen <= 1'b0;
		end else if (hit_valid) begin
			route_seen <= 1'b1;
		end
	end

endmodule

//--- tb/can_filter_assertions.sv
`timescale 1ns/1ps
module can_filter_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic hit_valid,
	input wire logic [3:0] hit_filter,
	input wire logic route_valid,
	input wire logic route_to_fifo,
	input wire logic [3:0] route_buffer,
	input wire logic [14:0] route_buffer_select,
	input wire logic [3:0] filter4_dest_ptr,
	input wire logic [3:0] filter9_dest_ptr,
	input wire logic [3:0] filter10_dest_ptr,
	input wire logic [3:0] filter11_dest_ptr,
	input wire logic [3:0] filter12_dest_ptr,
	input wire logic [3:0] filter14_dest_ptr
);
	logic w0;
	logic w1;
	// filter 9 stands in for the lookup, which is shared by every filter
	logic h9;
	assign w0 = psel && penable && pwrite && pstrb[0];
	assign w1 = psel && penable && pwrite && pstrb[1];
	assign h9 = hit_valid && hit_filter == 4'h9;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_f4_write: assert property (w0 && paddr == 12'h000 |=> filter4_dest_ptr == $past(pwdata[3:0]))
		else $error("filter4 field wrong");
	a_f11_write: assert property (w1 && paddr == 12'h004 |=> filter11_dest_ptr == $past(pwdata[15:12]))
		else $error("filter11 field wrong");
	a_f10_write: assert property (w1 && paddr == 12'h004 |=> filter10_dest_ptr == $past(pwdata[11:8]))
		else $error("filter10 field wrong");
	a_f9_write: assert property (w0 && paddr == 12'h004 |=> filter9_dest_ptr == $past(pwdata[7:4]))
		else $error("filter9 field wrong");
	a_upper_write: assert property (w0 && w1 && paddr == 12'h008 |=> {filter14_dest_ptr, 4'h0, filter12_dest_ptr} == ($past(pwdata[11:0]) & 12'hF0F))
		else $error("filter12 or 14 field wrong");
	a_fifo_route: assert property (h9 && filter9_dest_ptr == 4'hF |=> route_valid && route_to_fifo && route_buffer_select == 15'h0000)
		else $error("fifo route wrong");
	a_buffer_route: assert property (h9 && filter9_dest_ptr != 4'hF |=> route_valid && !route_to_fifo && route_buffer == $past(filter9_dest_ptr) && route_buffer_select == 15'h0001 << $past(filter9_dest_ptr))
		else $error("buffer route wrong");
	a_reset_clear: assert property ($rose(rst_n) |-> {filter4_dest_ptr, filter9_dest_ptr, filter14_dest_ptr} == 12'h000)
		else $error("pointer not cleared");
endmodule
bind can_filter_buffer_pointer can_filter_checker u_chk (.*);

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hit_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, lfsr = 32'h0000FBA5, prdata;
	logic [3:0] pstrb = 4'h0, hit_filter = 4'h0, route_buffer;
	logic pready, pslverr, route_valid, route_to_fifo, route_foreign;
	logic [14:0] route_buffer_select;
	logic [3:0] filter4_dest_ptr, filter5_dest_ptr, filter6_dest_ptr, filter7_dest_ptr, filter8_dest_ptr;
	logic [3:0] filter9_dest_ptr, filter10_dest_ptr, filter11_dest_ptr, filter12_dest_ptr;
	logic [3:0] filter13_dest_ptr, filter14_dest_ptr, filter15_dest_ptr;
	logic [15:0] mdl [0:2] = '{default: 16'h0};
	logic [32:0] q [$];
	logic [32:0] stat = 33'h0;
	logic [47:0] ptrs;
	int n_errors = 0, samples_checked = 0, cycles = 0;
	can_filter_buffer_pointer u_dut (.*);
	assign ptrs = {filter15_dest_ptr, filter14_dest_ptr, filter13_dest_ptr, filter12_dest_ptr, filter11_dest_ptr,
		filter10_dest_ptr, filter9_dest_ptr, filter8_dest_ptr, filter7_dest_ptr, filter6_dest_ptr, filter5_dest_ptr,
		filter4_dest_ptr};
	always #10 core_clk = ~core_clk;
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// slot 3 is a misaligned address inside the mapped range
	function automatic logic [11:0] adr(int r);
		return (r == 3) ? 12'h006 : (r == 4) ? 12'h00C : 12'(r * 4);
	endfunction
	task automatic apb(input logic w, input int r, input logic [31:0] d, input logic [3:0] s);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= adr(r);
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input int r, input logic [31:0] d, input logic [3:0] s);
		q.push_back({r == 3, 32'h0});
		apb(1'b1, r, d, s);
		if (r < 3 && s[0]) mdl[r][7:0] = d[7:0];
		if (r < 3 && s[1]) mdl[r][15:8] = d[15:8];
	endtask
	task automatic rd(input int r);
		q.push_back((r == 3) ? {1'b1, 32'h0} : (r == 4) ? stat : {17'h0, mdl[r]});
		apb(1'b0, r, 32'h0, 4'h0);
	endtask
	task automatic hit(input logic [3:0] f);
		logic [3:0] c;
		@(posedge core_clk);
		c = (f < 4) ? 4'h0 : mdl[(f - 4'h4) >> 2][f[1:0] * 4 +: 4];
		hit_valid <= 1'b1;
		hit_filter <= f;
		stat = {22'h0, 1'b1, f < 4, f >= 4 && c == 4'hF, f, c};
		q.push_back(f < 4 ? 33'h1 : c == 4'hF ? {13'h1, 20'h0} : {13'h0, c, 15'(15'h1 << c), 1'b0});
	endtask
	task automatic chk(input string n, input logic [32:0] g);
		logic [32:0] e;
		e = 'x;
		if (q.size() > 0) e = q.pop_front();
		samples_checked++;
		if (e !== g) begin
			$display("[ERR] %s exp %h got %h", n, e, g);
			n_errors++;
		end
	endtask
	// apb reads and routes never overlap, so one queue keeps their order
	always @(posedge core_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1) chk("prdata", {pslverr, prdata});
		if (route_valid === 1'b1) chk("route", {route_to_fifo, route_buffer, route_buffer_select, route_foreign});
		if (psel && penable && pwrite && pready === 1'b1) chk("pslverr", {pslverr, 32'h0});
		if (!psel && rst_n) begin
			samples_checked++;
			if (ptrs !== {mdl[2], mdl[1], mdl[0]}) begin
				$display("[ERR] dest_ptr exp %h got %h", {mdl[2], mdl[1], mdl[0]}, ptrs);
				n_errors++;
			end
		end
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		n_errors += q.size();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int r = 0; r < 5; r++) rd(r);
		$display("reset test done");
		for (int c = 0; c < 16; c++) begin
			lfsr = nxt(lfsr);
			wr(c % 3, lfsr & ~(32'hF << (c % 4 * 4)) | (c << (c % 4 * 4)), 4'hF);
			for (int f = 0; f < 16; f++) hit(4'(f));
			@(posedge core_clk);
			hit_valid <= 1'b0;
		end
		wr(1, 32'h0000_00F0, 4'h1);
		hit(4'h9);
		@(posedge core_clk);
		hit_valid <= 1'b0;
		$display("route test done");
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			wr(lfsr[9:8], lfsr, lfsr[3:0]);
			rd(lfsr[13:12]);
		end
		wr(4, lfsr, 4'hF);
		for (int r = 0; r < 5; r++) rd(r);
		$display("strobe test done");
		repeat (3) @(posedge core_clk);
		report_and_stop();
	end
endmodule
